// File: rtl/ssp_defines.svh
// register indices, field positions, reset values and timing counts of the serial port configuration
// assumes inclusion by bare name from the port module
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define IDX_SPI_MODE      3'h0
`define IDX_FLTR_SPEED    3'h1
`define IDX_HOLD_TIMING   3'h2
`define IDX_TARGET_ADDR   3'h3
`define IDX_GLOBAL        3'h4
`define RST_SPI_MODE      8'h21
`define RST_FLTR_SPEED    8'h01
`define RST_HOLD_TIMING   8'h44
`define RST_TARGET_ADDR   8'h09
`define RST_ADDR_LSB      2'h1
`define RST_GLOBAL        8'h01
`define MASK_SPI_MODE     8'h7b
`define MASK_FLTR_SPEED   8'h3f
`define MASK_HOLD_TIMING  8'hff
`define MASK_TARGET_ADDR  8'h7c
`define MASK_GLOBAL       8'h07
`define SPI_DSIZE_LSB     5
`define SPI_DEN_BIT       4
`define SPI_DEL_BIT       3
`define SPI_CLKSEL_BIT    1
`define SPI_3W_BIT        0
`define FLTR_SPEED_LSB    4
`define HOLD_HI_LSB       4
`define GLOB_ASIZE_BIT    2
`define HOLD_MULT_SHIFT   3
`define STRAP_CAPTURE_CYC 2'h2
`endif

// File: rtl/ssp_pkg.sv
// types shared by the serial port configuration block and its bench
// assumes ssp_defines.svh sits beside it
package ssp_pkg;
  typedef enum logic [1:0] {
    PORT_OFF  = 2'h0,
    PORT_I2C  = 2'h1,
    PORT_SPI  = 2'h2,
    PORT_RSVD = 2'h3
  } port_mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_HEAD, ST_ADDR_HI, ST_ADDR_LO, ST_DUMMY, ST_WDATA, ST_RDATA, ST_IGNORE} txn_state_t;
  typedef struct packed {
    logic       en;
    logic [2:0] idx;
    logic [7:0] data;
  } cfg_wr_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } csr_req_t;
endpackage : ssp_pkg

// File: rtl/serial_slave_port_config.sv
// slave serial port: configuration registers, i2c target and 3/4-wire spi slave front end
// assumes pins arrive asynchronous to core_clk_i; register file answers csr reads in the same cycle as the request
// Operation
// - dummy enabled: shift out one, two or three dummy bytes per size code.
// - dummy disabled: read data follows the address directly, else dummies first.
// - drive output on edge opposite sampling, or half an spi clock later.
// - sample spi input on rising edge when select is 0, falling when 1.
// - three-wire mode (default) sends and receives on the shared data pin.
// - i2c speed field only sets output drive strength.
// - spike filters on clock and data, length equal to filter field in cycles.
// - filter field zero turns filtering off.
// - wait eight times high-hold field cycles before driving a one.
// - wait eight times low-hold field cycles before driving a zero.
// - acknowledge i2c accesses only at the configured seven-bit target address.
// - two low address bits come from otp or straps, never from writes.
// - one register address byte when size bit is 0, two when 1.
// - full 32-bit address takes upper bits from the page register.
// - mode field: off, i2c (default), spi, reserved.
// - four-wire spi puts read data on serial out, else the selected status.
`include "ssp_defines.svh"
module serial_slave_port_config (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  // configuration access
  input  wire ssp_pkg::cfg_wr_t  cfg_wr_i,
  input  wire logic [2:0]        cfg_rd_idx_i,
  output logic [7:0]             cfg_rdata_o,
  // address low bits
  input  wire logic [1:0]        otp_addr_lsb_i,
  input  wire logic              strap_override_i,
  input  wire logic [1:0]        strap_addr_lsb_i,
  // serial pins
  input  wire logic              scl_sclk_i,
  input  wire logic              cs_n_i,
  input  wire logic              shared_data_pin_i,
  output logic                   shared_data_pin_o,
  output logic                   shared_data_pin_oe_o,
  output logic                   serial_out_o,
  output logic                   serial_out_oe_o,
  output logic [1:0]             i2c_drive_o,
  // status for serial out
  input  wire logic [15:0]       status_i,
  input  wire logic [3:0]        status_sel_i,
  // internal register access
  input  wire logic [31:0]       page_i,
  output ssp_pkg::csr_req_t      csr_req_o,
  input  wire logic [7:0]        csr_rdata_i
);
  import ssp_pkg::*;

  function automatic logic [31:0] full_addr(input logic [31:0] page, input logic [15:0] ptr, input logic two);
    full_addr = two ? {page[31:16], ptr} : {page[31:8], ptr[7:0]};
  endfunction : full_addr

  ////////////////////////////////////////////////////////////////////////////////////////////////
  logic [7:0] spi_q, fltr_q, hold_q, addr_q, glob_q;
  logic [1:0] lsb_q, cap_cnt_q;
  logic [2:0] strap1_q, strap2_q;
  logic [6:0] target;
  logic       is_i2c, is_spi, addr2, dummy_en, del_out, clk_sel, three_wire;
  logic [1:0] dsize;
  logic [3:0] spike, hi_hold, lo_hold;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      spi_q  <= `RST_SPI_MODE;
      fltr_q <= `RST_FLTR_SPEED;
      hold_q <= `RST_HOLD_TIMING;
      addr_q <= `RST_TARGET_ADDR & `MASK_TARGET_ADDR;
      glob_q <= `RST_GLOBAL;
    end else if (cfg_wr_i.en) begin
      case (cfg_wr_i.idx)
        `IDX_SPI_MODE:    spi_q  <= cfg_wr_i.data & `MASK_SPI_MODE;
        `IDX_FLTR_SPEED:  fltr_q <= cfg_wr_i.data & `MASK_FLTR_SPEED;
        `IDX_HOLD_TIMING: hold_q <= cfg_wr_i.data & `MASK_HOLD_TIMING;
        `IDX_TARGET_ADDR: addr_q <= cfg_wr_i.data & `MASK_TARGET_ADDR;
        `IDX_GLOBAL:      glob_q <= cfg_wr_i.data & `MASK_GLOBAL;
        default:          ;
      endcase
    end
  end

  // strap pins synchronised, low address bits caught once after reset release
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      strap1_q  <= 3'h0;
      strap2_q  <= 3'h0;
      cap_cnt_q <= 2'h0;
      lsb_q     <= `RST_ADDR_LSB;
    end else begin
      strap1_q <= {strap_override_i, strap_addr_lsb_i};
      strap2_q <= strap1_q;
      if (cap_cnt_q != 2'h3) cap_cnt_q <= cap_cnt_q + 2'h1;
      if (cap_cnt_q == `STRAP_CAPTURE_CYC) lsb_q <= strap2_q[2] ? strap2_q[1:0] : otp_addr_lsb_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) cfg_rdata_o <= 8'h00;
    else begin
      case (cfg_rd_idx_i)
        `IDX_SPI_MODE:    cfg_rdata_o <= spi_q;
        `IDX_FLTR_SPEED:  cfg_rdata_o <= fltr_q;
        `IDX_HOLD_TIMING: cfg_rdata_o <= hold_q;
        `IDX_TARGET_ADDR: cfg_rdata_o <= {1'b0, target};
        `IDX_GLOBAL:      cfg_rdata_o <= glob_q;
        default:          cfg_rdata_o <= 8'h00;
      endcase
    end
  end

  assign target     = {addr_q[6:2], lsb_q};
  assign is_i2c     = port_mode_t'(glob_q[1:0]) == PORT_I2C;
  assign is_spi     = port_mode_t'(glob_q[1:0]) == PORT_SPI;
  assign addr2      = glob_q[`GLOB_ASIZE_BIT];
  assign dsize      = spi_q[`SPI_DSIZE_LSB +: 2];
  assign dummy_en   = spi_q[`SPI_DEN_BIT];
  assign del_out    = spi_q[`SPI_DEL_BIT];
  assign clk_sel    = spi_q[`SPI_CLKSEL_BIT];
  assign three_wire = spi_q[`SPI_3W_BIT];
  assign spike      = fltr_q[3:0];
  assign hi_hold    = hold_q[`HOLD_HI_LSB +: 4];
  assign lo_hold    = hold_q[3:0];
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) i2c_drive_o <= 2'h0;
    else i2c_drive_o <= fltr_q[`FLTR_SPEED_LSB +: 2];
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers {clock, data, select} and i2c spike filters {scl, sda}
  logic [2:0] sync1_q, sync2_q;
  logic [1:0] filt_q, prev_q;
  logic [3:0] fcnt_q [2];
  logic       line_clk, line_dat, csn, rise, fall, i2c_start, i2c_stop;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
    end else begin
      sync1_q <= {scl_sclk_i, shared_data_pin_i, cs_n_i};
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      filt_q <= 2'h3;
      fcnt_q <= '{4'h0, 4'h0};
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (spike == 4'h0) begin
          filt_q[k] <= sync2_q[k+1];
          fcnt_q[k] <= 4'h0;
        end else if (sync2_q[k+1] != filt_q[k]) begin
          if (4'(fcnt_q[k] + 4'h1) >= spike) begin
            filt_q[k] <= sync2_q[k+1];
            fcnt_q[k] <= 4'h0;
          end else fcnt_q[k] <= fcnt_q[k] + 4'h1;
        end else fcnt_q[k] <= 4'h0;
      end
    end
  end

  assign line_clk  = is_i2c ? filt_q[1] : sync2_q[2];
  assign line_dat  = is_i2c ? filt_q[0] : sync2_q[1];
  assign csn       = sync2_q[0];
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) prev_q <= 2'h3;
    else prev_q <= {line_clk, line_dat};
  end
  assign rise      = line_clk & ~prev_q[1];
  assign fall      = ~line_clk & prev_q[1];
  assign i2c_start = is_i2c & line_clk & prev_q[1] & prev_q[0] & ~line_dat;
  assign i2c_stop  = is_i2c & line_clk & prev_q[1] & ~prev_q[0] & line_dat;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // bit and byte framing
  logic       spi_act, sample, drive_edge, frame_reset, byte_done, ack_slot;
  logic [3:0] bit_q;
  logic [7:0] rx_q, nb;

  assign spi_act     = is_spi & ~csn;
  assign sample      = is_i2c ? rise : spi_act & (clk_sel ? fall : rise);
  assign drive_edge  = spi_act & (del_out ? sample : (clk_sel ? rise : fall));
  assign frame_reset = ~(is_spi | is_i2c) | (is_spi & csn) | i2c_start | i2c_stop;
  assign byte_done   = sample & (bit_q == 4'h7);
  assign ack_slot    = is_i2c & sample & (bit_q == 4'h8);
  assign nb          = {rx_q[6:0], line_dat};

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || frame_reset) begin
      bit_q <= 4'h0;
      rx_q  <= 8'h00;
    end else if (sample) begin
      bit_q <= (bit_q == (is_i2c ? 4'h8 : 4'h7)) ? 4'h0 : bit_q + 4'h1;
      if (bit_q < 4'h8) rx_q <= nb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // transaction sequencing
  txn_state_t  txn_q, txn_d;
  logic        rw_q, rw_d, ack_q, ack_d, issue_rd, issue_wr, zero_ld, load_q;
  logic [1:0]  dummy_q, dummy_d;
  logic [15:0] ptr_q, ptr_d, acc_ptr;
  csr_req_t    req_q;

  always_comb begin
    txn_d = txn_q;
    rw_d = rw_q;
    ack_d = ack_q;
    dummy_d = dummy_q;
    ptr_d = ptr_q;
    issue_rd = 1'b0;
    issue_wr = 1'b0;
    zero_ld = 1'b0;
    if (frame_reset) begin
      txn_d = (is_spi || i2c_start) ? ST_HEAD : ST_IDLE;
      ack_d = 1'b0;
    end else if (byte_done) begin
      ack_d = 1'b1;
      case (txn_q)
        ST_HEAD: begin
          if (is_i2c && nb[7:1] != target) begin
            txn_d = ST_IGNORE;
            ack_d = 1'b0;
          end else begin
            rw_d = is_i2c ? nb[0] : nb[7];
            if (is_i2c && nb[0]) begin
              txn_d = ST_RDATA;
              issue_rd = 1'b1;
            end else txn_d = addr2 ? ST_ADDR_HI : ST_ADDR_LO;
          end
        end
        ST_ADDR_HI: begin
          ptr_d[15:8] = nb;
          txn_d = ST_ADDR_LO;
        end
        ST_ADDR_LO: begin
          ptr_d = {addr2 ? ptr_q[15:8] : 8'h00, nb};
          if (is_spi && rw_q) begin
            if (dummy_en) begin
              txn_d = ST_DUMMY;
              dummy_d = (dsize == 2'h0) ? 2'h0 : 2'(dsize - 2'h1);
              zero_ld = 1'b1;
            end else begin
              txn_d = ST_RDATA;
              issue_rd = 1'b1;
            end
          end else txn_d = ST_WDATA;
        end
        ST_DUMMY: begin
          if (dummy_q == 2'h0) begin
            txn_d = ST_RDATA;
            issue_rd = 1'b1;
          end else begin
            dummy_d = 2'(dummy_q - 2'h1);
            zero_ld = 1'b1;
          end
        end
        ST_WDATA: issue_wr = 1'b1;
        ST_RDATA: begin
          issue_rd = is_spi;
          ack_d = 1'b0;
        end
        default: ack_d = 1'b0;
      endcase
    end else if (ack_slot && txn_q == ST_RDATA) begin
      if (!line_dat) issue_rd = 1'b1;
      else txn_d = ST_IGNORE;
    end
    acc_ptr = ptr_d;
    if (issue_rd || issue_wr) ptr_d = ptr_d + 16'h1;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      txn_q <= ST_IDLE;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      dummy_q <= 2'h0;
      ptr_q <= 16'h0000;
    end else begin
      txn_q <= txn_d;
      rw_q <= rw_d;
      ack_q <= ack_d;
      dummy_q <= dummy_d;
      ptr_q <= ptr_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      req_q <= '0;
      load_q <= 1'b0;
    end else begin
      req_q.valid <= issue_rd | issue_wr;
      req_q.write <= issue_wr;
      req_q.addr <= full_addr(page_i, acc_ptr, addr2);
      req_q.wdata <= nb;
      load_q <= issue_rd;
    end
  end
  assign csr_req_o = req_q;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // transmit shifter and pin drive
  logic [7:0] tx_q;
  logic [6:0] hcnt_q, hlimit;
  logic       out_q, want_q, drv_q, sout_q, tx_phase;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || frame_reset) begin
      tx_q <= 8'h00;
      out_q <= 1'b0;
    end else if (load_q) begin
      tx_q <= csr_rdata_i;
    end else if (zero_ld) begin
      tx_q <= 8'h00;
      if (del_out) out_q <= 1'b0;
    end else if (drive_edge || (is_i2c && fall && bit_q < 4'h8 && txn_q == ST_RDATA)) begin
      out_q <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // i2c data: wanted level set on scl fall, applied after the hold delay
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !is_i2c || i2c_start || i2c_stop) want_q <= 1'b1;
    else if (fall) want_q <= (bit_q == 4'h8) ? ~ack_q : (txn_q == ST_RDATA ? tx_q[7] : 1'b1);
  end

  assign hlimit = {want_q ? hi_hold : lo_hold, 3'b000};
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      drv_q <= 1'b1;
      hcnt_q <= 7'h00;
    end else if (want_q == drv_q) hcnt_q <= 7'h00;
    else if (hcnt_q >= hlimit) begin
      drv_q <= want_q;
      hcnt_q <= 7'h00;
    end else hcnt_q <= hcnt_q + 7'h01;
  end

  assign tx_phase = txn_q == ST_DUMMY || txn_q == ST_RDATA;
  assign shared_data_pin_o = is_i2c ? 1'b0 : out_q;
  assign shared_data_pin_oe_o = (is_i2c & ~drv_q) | (spi_act & three_wire & tx_phase);
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) sout_q <= 1'b0;
    else sout_q <= (is_spi && !three_wire) ? out_q : status_i[status_sel_i];
  end
  assign serial_out_o = sout_q;
  assign serial_out_oe_o = !(is_spi && !three_wire) || !csn;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_off_idle;
    !(is_i2c || is_spi) |=> !csr_req_o.valid;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("access issued while port disabled");
  property p_fltr_bypass;
    spike == 4'h0 |=> filt_q == $past(sync2_q[2:1]);
  endproperty
  a_fltr_bypass: assert property (p_fltr_bypass) else $error("filter not bypassed at zero");
  property p_fltr_len;
    spike != 4'h0 && $stable(spike) && $past(spike, 2) == spike && $changed(filt_q[0]) |->
      $past(fcnt_q[0]) == 4'(spike - 4'h1);
  endproperty
  a_fltr_len: assert property (p_fltr_len) else $error("sda filter length wrong");
  property p_hold_one;
    $rose(drv_q) && $stable(hold_q) |-> $past(hcnt_q) == {hi_hold, 3'b000};
  endproperty
  a_hold_one: assert property (p_hold_one) else $error("high hold delay wrong");
  property p_hold_zero;
    $fell(drv_q) && $stable(hold_q) |-> $past(hcnt_q) == {lo_hold, 3'b000};
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("low hold delay wrong");
  property p_addr_match;
    is_i2c && byte_done && txn_q == ST_HEAD && nb[7:1] != target |=> txn_q == ST_IGNORE ##1 !csr_req_o.valid;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("foreign address accepted");
  property p_lsb_fixed;
    cap_cnt_q == 2'h3 |=> $stable(target[1:0]);
  endproperty
  a_lsb_fixed: assert property (p_lsb_fixed) else $error("address low bits changed");
  property p_addr_size;
    byte_done && txn_q == ST_HEAD && !ack_slot && !(is_i2c && (nb[0] || nb[7:1] != target)) |=>
      txn_q == (($past(addr2)) ? ST_ADDR_HI : ST_ADDR_LO);
  endproperty
  a_addr_size: assert property (p_addr_size) else $error("address byte count wrong");
  property p_page;
    csr_req_o.valid |-> csr_req_o.addr[31:16] == $past(page_i[31:16]);
  endproperty
  a_page: assert property (p_page) else $error("page bits not used");
  property p_no_dummy;
    is_spi && byte_done && txn_q == ST_ADDR_LO && rw_q && !dummy_en |=> csr_req_o.valid && !csr_req_o.write;
  endproperty
  a_no_dummy: assert property (p_no_dummy) else $error("read not issued after address");

  c_spi_dummy: cover property (is_spi && txn_q == ST_DUMMY ##[1:300] csr_req_o.valid);
  c_i2c_write: cover property (is_i2c && csr_req_o.valid && csr_req_o.write);
  c_i2c_read: cover property (is_i2c && csr_req_o.valid && !csr_req_o.write);
  c_shared_data_wire_mode: cover property (shared_data_pin_oe_o && is_spi);
endmodule : serial_slave_port_config

// File: verif/spi_host_model.sv
// spi host model: drives clock, chip select and data toward the serial port
// assumes the bench resolves the shared data wire from both enables
module spi_host_model (
  // pins toward the port
  output logic       sclk_o,
  output logic       cs_n_o,
  output logic       mosi_o,
  output logic       mosi_oe_o,
  input  wire logic  miso_i,
  // received bytes
  output logic       rx_stb_o,
  output logic [7:0] rx_byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idle_lvl;
  initial begin
    {idle_lvl, sclk_o, mosi_o, mosi_oe_o, rx_stb_o} = '0;
    cs_n_o    = 1'b1;
    rx_byte_o = 8'h00;
  end
  ////////////////////////////////////////
  // clock idles at the non-sampling level
  task automatic start(input logic sel);
    idle_lvl  = sel;
    sclk_o    = sel;
    #40 cs_n_o = 1'b0;
    mosi_oe_o = 1'b1;
    #40;
  endtask : start
  task automatic stop();
    #40 cs_n_o = 1'b1;
    mosi_oe_o = 1'b0;
    #120;
  endtask : stop
  // one byte, msb first, 64 ns per bit
  task automatic xfer(input logic [7:0] tx, input logic listen, input logic free, input int gap);
    logic [7:0] rx;
    #gap;
    for (int i = 7; i >= 0; i--) begin
      mosi_o    = tx[i];
      mosi_oe_o = !free;
      #32 sclk_o = ~idle_lvl;
      #28 rx[i] = miso_i;
      #4 sclk_o = idle_lvl;
    end
    if (listen) begin
      rx_byte_o = rx;
      rx_stb_o  = 1'b1;
      #8 rx_stb_o = 1'b0;
    end
  endtask : xfer
  // i2c write of three bytes, ack bits released, framed by start and stop
  task automatic i2c_write(input logic [23:0] b);
    mosi_o    = 1'b1;
    mosi_oe_o = 1'b1;
    #32 sclk_o = 1'b1;
    #32 mosi_o = 1'b0;
    #32 sclk_o = 1'b0;
    for (int i = 26; i >= 0; i--) begin
      mosi_o = (i % 9 == 0) ? 1'b1 : b[i - i / 9 - 1];
      #32 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
    mosi_o = 1'b0;
    #32 sclk_o = 1'b1;
    #32 mosi_o = 1'b1;
    #64;
  endtask : i2c_write
endmodule : spi_host_model

// File: verif/testbench.sv
// bench for the serial port configuration block
// assumes the spi host model and the design package are compiled first
`define CHK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, (got), (exp)); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ssp_pkg::*;
  logic        clk, rst, strap_ov, float_q, wire4, live, sclk, cs_n, mosi, mosi_oe;
  logic        rx_stb, pin_in, pin_o, pin_oe, so, so_oe, miso;
  logic [1:0]  otp, strap, drive;
  logic [2:0]  rd_idx;
  logic [3:0]  sel;
  logic [7:0]  cfg_rd, rx_byte, csr_rd, exp_b;
  logic [15:0] status;
  logic [31:0] page, seed;
  cfg_wr_t     cfg_wr;
  csr_req_t    req, exp_r;
  csr_req_t    wr_q[$];
  logic [7:0]  rd_q[$];
  int          err_count, n_checks, cyc, n_req, n_was;
  logic [7:0]  rst_v [6] = '{8'h21, 8'h01, 8'h44, 8'h0a, 8'h01, 8'h00};
  logic [7:0]  msk_v [6] = '{8'h7b, 8'h3f, 8'hff, 8'h7e, 8'h07, 8'h00};
  assign pin_in = pin_oe ? pin_o : (mosi_oe ? mosi : float_q);
  assign miso   = wire4 ? (so_oe ? so : float_q) : pin_in;
  serial_slave_port_config u_serial_slave_port_config (
    .core_clk_i(clk), .sys_rst_i(rst), .cfg_wr_i(cfg_wr), .cfg_rd_idx_i(rd_idx), .cfg_rdata_o(cfg_rd),
    .otp_addr_lsb_i(otp), .strap_override_i(strap_ov), .strap_addr_lsb_i(strap),
    .scl_sclk_i(sclk), .cs_n_i(cs_n), .shared_data_pin_i(pin_in), .shared_data_pin_o(pin_o),
    .shared_data_pin_oe_o(pin_oe), .serial_out_o(so), .serial_out_oe_o(so_oe), .i2c_drive_o(drive),
    .status_i(status), .status_sel_i(sel), .page_i(page), .csr_req_o(req), .csr_rdata_i(csr_rd));
  spi_host_model u_spi_host_model (
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .mosi_oe_o(mosi_oe), .miso_i(miso),
    .rx_stb_o(rx_stb), .rx_byte_o(rx_byte));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [7:0] dat(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ a[31:24];
  endfunction : dat
  task automatic wrap_up();
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  task automatic wr_cfg(input logic [2:0] idx, input logic [7:0] d);
    @(negedge clk) cfg_wr = '{1'b1, idx, d};
    @(negedge clk) cfg_wr.en = 1'b0;
  endtask : wr_cfg
  task automatic chk_cfg(input logic [2:0] idx, input logic [7:0] exp);
    @(negedge clk) rd_idx = idx;
    @(negedge clk) `CHK(cfg_rd, exp)
  endtask : chk_cfg
  // one spi frame: command, address, dummies, data
  task automatic frame(input logic rd, two, input int n, ndum, input logic ck);
    logic [31:0] adr;
    @(negedge clk);
    page = rnd();
    void'(rnd());
    adr  = two ? {page[31:16], seed[15:8], 1'b0, seed[6:0]} : {page[31:8], 1'b0, seed[6:0]};
    u_spi_host_model.start(ck);
    u_spi_host_model.xfer({rd, 7'h00}, 1'b0, 1'b0, 0);
    if (two) u_spi_host_model.xfer(adr[15:8], 1'b0, 1'b0, 0);
    u_spi_host_model.xfer(adr[7:0], 1'b0, 1'b0, 0);
    repeat (ndum) begin
      rd_q.push_back(8'h00);
      u_spi_host_model.xfer(8'h00, 1'b1, !wire4, 64);
    end
    for (int i = 0; i < n; i++) begin
      void'(rnd());
      if (rd) begin
        rd_q.push_back(dat(adr + 32'(i)));
        u_spi_host_model.xfer(8'h00, 1'b1, !wire4, 64);
      end else begin
        if (live) wr_q.push_back('{1'b1, 1'b1, adr + 32'(i), seed[7:0]});
        u_spi_host_model.xfer(seed[7:0], 1'b0, 1'b0, 0);
      end
    end
    u_spi_host_model.stop();
  endtask : frame
  ////////////////////////////////////////
  always @(negedge clk) if (req.valid === 1'b1) csr_rd <= dat(req.addr);
  always @(posedge clk) begin
    float_q <= ~float_q;
    cyc     <= cyc + 1;
    if (!rst && req.valid === 1'b1) n_req <= n_req + 1;
    if (cyc == 30000) begin
      err_count++;
      $display("wrong value at %0t: timeout", $time);
      wrap_up();
    end
    if (!rst && req.valid === 1'b1 && req.write === 1'b1) begin
      exp_r = wr_q.size() > 0 ? wr_q.pop_front() : '0;
      `CHK(req, exp_r)
    end
  end
  always @(posedge rx_stb) begin
    exp_b = rd_q.size() > 0 ? rd_q.pop_front() : 8'hxx;
    `CHK(rx_byte, exp_b)
  end
  ////////////////////////////////////////
  initial begin
    {rst, strap_ov, float_q, wire4, live} = 5'b10001;
    {otp, strap, rd_idx, sel, status, page} = {2'h2, 2'h3, 3'h0, 4'h0, 16'h0000, 32'h0000_0000};
    {cfg_wr, csr_rd, err_count, n_checks, cyc, n_req, n_was} = '0;
    seed = 32'h2c1c;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    `CHK(drive, 2'h0)
    `CHK(so_oe, 1'b1)
    for (int i = 0; i < 6; i++) chk_cfg(3'(i), rst_v[i]);
    for (int i = 0; i < 6; i++) begin
      wr_cfg(3'(i), 8'hff);
      chk_cfg(3'(i), msk_v[i]);
    end
    wr_cfg(3'h3, 8'h00);
    chk_cfg(3'h3, 8'h02);
    for (int s = 0; s < 4; s++) begin
      wr_cfg(3'h1, {2'h0, 2'(s), 4'(s)});
      @(negedge clk);
      `CHK(drive, 2'(s))
    end
    wr_cfg(3'h4, 8'h01);
    repeat (4) begin
      void'(rnd());
      {sel, status} = seed[19:0];
      repeat (3) @(negedge clk);
      `CHK(so, status[sel])
    end
    wr_cfg(3'h4, 8'h02);
    wr_cfg(3'h0, 8'h01);
    frame(1'b0, 1'b0, 2, 0, 1'b0);
    frame(1'b1, 1'b0, 2, 0, 1'b0);
    wr_cfg(3'h0, 8'h03);
    frame(1'b0, 1'b0, 2, 0, 1'b1);
    wr_cfg(3'h4, 8'h06);
    wr_cfg(3'h0, 8'h01);
    frame(1'b0, 1'b1, 2, 0, 1'b0);
    frame(1'b1, 1'b1, 1, 0, 1'b0);
    wr_cfg(3'h4, 8'h02);
    for (int d = 1; d < 4; d++) begin
      wr_cfg(3'h0, {1'b0, 2'(d), 1'b1, d[0], 3'b001});
      frame(1'b1, 1'b0, 1, d, 1'b0);
    end
    wr_cfg(3'h0, 8'h00);
    wire4 = 1'b1;
    @(negedge clk);
    `CHK(so_oe, 1'b0)
    frame(1'b1, 1'b0, 2, 0, 1'b0);
    frame(1'b0, 1'b0, 1, 0, 1'b0);
    wire4 = 1'b0;
    wr_cfg(3'h4, 8'h00);
    live = 1'b0;
    frame(1'b0, 1'b0, 2, 0, 1'b0);
    @(negedge clk) rst = 1'b1;
    strap_ov = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    chk_cfg(3'h3, 8'h0b);
    n_was = n_req;
    u_spi_host_model.i2c_write({7'h0c, 1'b0, 8'h10, 8'h5a});
    repeat (8) @(negedge clk);
    `CHK(n_req, n_was)
    repeat (20) @(negedge clk);
    `CHK(wr_q.size() + rd_q.size(), 0)
    wrap_up();
  end
endmodule : testbench
